// ### swc_regs.svh
`ifndef SWC_REGS_SVH
`define SWC_REGS_SVH

// Register indices; byte address is four times the index
`define SWC_IDX_STRAP 12'h210
`define SWC_IDX_OPER 12'h300
`define SWC_IDX_ADDR0 12'h302
`define SWC_IDX_ADDR1 12'h303
`define SWC_IDX_ADDR2 12'h304
`define SWC_IDX_ADDR3 12'h305
`define SWC_IDX_ADDR4 12'h306
`define SWC_IDX_ADDR5 12'h307
`define SWC_IDX_MFL 12'h308
`define SWC_IDX_TAG 12'h30a
`define SWC_IDX_CBS 12'h30e
`define SWC_ADDR_W 14

// Field positions
`define SWC_OPER_DTAG 7
`define SWC_OPER_SRST 1
`define SWC_OPER_START 0
`define SWC_CBS_SHAPE 1
`define SWC_CBS_POLICE 0
`define SWC_STRAP_LED_A0 0
`define SWC_MFL_LEN_W 14

// Reset values
`define SWC_RST_DTAG 1'b0
`define SWC_RST_ADDR3 8'hff
`define SWC_RST_ADDR4 8'hff
`define SWC_RST_ADDR5 8'hff
`define SWC_RST_MFL 14'h07d0
`define SWC_RST_MFL_RSV 2'h0
`define SWC_RST_TAG 16'h9100
`define SWC_RST_SHAPE 1'b0
`define SWC_RST_POLICE 1'b1

// Strap settle time in clock cycles after reset release
`define SWC_STRAP_SETTLE 3'd4

`endif

// ### swc_pkg.sv
package swc_pkg;

   typedef logic [3:0] swc_strap_t;
   typedef logic [47:0] swc_mac_t;
   typedef logic [7:0] swc_byte_t;

   typedef enum logic [0:0]
   {
      SWC_BUS_IDLE = 1'b0,
      SWC_BUS_ANS = 1'b1
   } swc_bus_st_t;

endpackage

// ### swc_strap_if.sv
interface swc_strap_if;
   swc_pkg::swc_strap_t value;
   logic valid;

   modport src (output value, output valid);
   modport dst (input value, input valid);
endinterface

// ### swc_strap_latch.sv
`include "swc_regs.svh"

module swc_strap_latch (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Strap pins
   input wire logic rxd_b1,
   input wire logic rxd_b0,
   input wire logic led_a1,
   input wire logic led_a0,
   // Latched straps
   swc_strap_if.src strap
);
   import swc_pkg::*;

   swc_strap_t s1_q;
   swc_strap_t s2_q;
   swc_strap_t s3_q;
   logic [2:0] settle_q;

   // Pins are asynchronous; only the second stage reads the first
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         s1_q <= 4'h0;
         s2_q <= 4'h0;
         s3_q <= 4'h0;
      end
      else
      begin
         s1_q <= {rxd_b1, rxd_b0, led_a1, led_a0};
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // Caught once after hardware reset; soft reset never recaptures
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         settle_q <= 3'h0;
         strap.valid <= 1'b0;
         strap.value <= 4'h0;
      end
      else if (!strap.valid)
      begin
         if (settle_q != `SWC_STRAP_SETTLE)
            settle_q <= settle_q + 3'h1;
         else if (s2_q == s3_q)
         begin
            strap.value <= s3_q;
            strap.valid <= 1'b1;
         end
      end
   end

   AST_STRAP_HELD: assert property (@(posedge clk) disable iff (!rst_n)
      strap.valid |=> strap.valid && $stable(strap.value))
      else $error("Strap value changed after capture");

endmodule

// ### swc_global_ctrl.sv
// What this block does
// - Read-only bits 3:0 show latched straps rxd_b1, rxd_b0, led_a1, led_a0.
// - Operation bit 7 enables double tagging; resets to zero.
// - Writing operation bit 1 restores defaults except straps, then self-clears.
// - Operation bit 0 low blocks all forwarding; high lets switching run.
// - Start bit reset value comes from the led_a0 strap.
// - Own address feeds pause frame source and self-address filtering.
// - 14-bit maximum frame length, reset 0x07d0, longer frames get truncated.
// - 16-bit tag identifier, reset 0x9100, default and outer provider tag.
// - Shaper strategy bit 1 adds gap and preamble to shaper credit; reset 0.
// - Shaper strategy bit 0 adds gap and preamble to policing; reset 1.
`include "swc_regs.svh"

module swc_global_ctrl #(
   // Reset value of the top three address bytes; arbitrary
   parameter logic [23:0] OWN_ADDR_HI_RST = 24'h025a3c
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Strap pins
   input wire logic rxd_b1,
   input wire logic rxd_b0,
   input wire logic led_a1,
   input wire logic led_a0,
   // Avalon-MM slave
   input wire logic [`SWC_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Switch controls
   output logic switch_enable,
   output logic double_tag_en,
   output logic soft_reset_busy,
   output swc_pkg::swc_mac_t own_addr,
   output logic [`SWC_MFL_LEN_W-1:0] max_frame_length,
   output logic [15:0] provider_tag,
   output logic shaper_credit_full,
   output logic police_credit_full
);
   import swc_pkg::*;

   swc_strap_if strap ();

   swc_bus_st_t bus_q;
   logic wait_q;
   logic [31:0] rdata_q;
   logic [31:0] rd_mux;
   logic take;
   logic wr_take;
   logic cfg_rst;
   logic strap_seen_q;
   logic strap_load;
   logic srst_q;
   logic start_q;
   logic dtag_q;
   swc_byte_t addr_q [6];
   logic [`SWC_MFL_LEN_W-1:0] mfl_q;
   logic [1:0] mfl_rsv_q;
   logic [15:0] tag_q;
   logic shape_q;
   logic police_q;

   function automatic logic hit(input logic [`SWC_ADDR_W-1:0] a, input logic [11:0] idx);
      return a == {idx, 2'b00};
   endfunction

   function automatic swc_byte_t merge(input swc_byte_t old, input swc_byte_t nw,
                                       input logic en);
      return en ? nw : old;
   endfunction

   swc_strap_latch u_strap (
      .clk(clk),
      .rst_n(rst_n),
      .rxd_b1(rxd_b1),
      .rxd_b0(rxd_b0),
      .led_a1(led_a1),
      .led_a0(led_a0),
      .strap(strap.src)
   );

   // Bus answers one cycle after a request; the write lands on the answer edge
   assign take = (bus_q == SWC_BUS_ANS);
   assign wr_take = take && avs_write;
   assign cfg_rst = !rst_n || srst_q;
   assign strap_load = strap.valid && !strap_seen_q;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         bus_q <= SWC_BUS_IDLE;
         wait_q <= 1'b1;
         rdata_q <= 32'h0;
      end
      else
      begin
         case (bus_q)
            SWC_BUS_IDLE:
            begin
               if (avs_read || avs_write)
               begin
                  bus_q <= SWC_BUS_ANS;
                  wait_q <= 1'b0;
                  rdata_q <= avs_read ? rd_mux : 32'h0;
               end
            end
            SWC_BUS_ANS:
            begin
               bus_q <= SWC_BUS_IDLE;
               wait_q <= 1'b1;
            end
            default:
            begin
               bus_q <= SWC_BUS_IDLE;
               wait_q <= 1'b1;
            end
         endcase
      end
   end

   // Unmapped addresses read zero; reserved bits are zero-filled except length bits 15:14, which read back as written
   always_comb
   begin
      rd_mux = 32'h0;
      if (hit(avs_address, `SWC_IDX_STRAP))
         rd_mux = {28'h0, strap.value};
      else if (hit(avs_address, `SWC_IDX_OPER))
         rd_mux = {24'h0, dtag_q, 5'h00, srst_q, start_q};
      else if (hit(avs_address, `SWC_IDX_MFL))
         rd_mux = {16'h0, mfl_rsv_q, mfl_q};
      else if (hit(avs_address, `SWC_IDX_TAG))
         rd_mux = {16'h0, tag_q};
      else if (hit(avs_address, `SWC_IDX_CBS))
         rd_mux = {30'h0, shape_q, police_q};
      else
      begin
         for (int i = 0; i < 6; i++)
         begin
            if (hit(avs_address, `SWC_IDX_ADDR0 + 12'(i)))
               rd_mux = {24'h0, addr_q[i]};
         end
      end
   end

   // Self-clearing: high for one cycle, then the next edge restores defaults
   always_ff @(posedge clk)
   begin
      if (cfg_rst)
         srst_q <= 1'b0;
      else if (wr_take && hit(avs_address, `SWC_IDX_OPER) && avs_byteenable[0])
         srst_q <= avs_writedata[`SWC_OPER_SRST];
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         strap_seen_q <= 1'b0;
      else if (strap.valid)
         strap_seen_q <= 1'b1;
   end

   // Start default is the strap; held off until the strap is caught
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         start_q <= 1'b0;
      else if (srst_q || strap_load)
         start_q <= strap.value[`SWC_STRAP_LED_A0];
      else if (wr_take && hit(avs_address, `SWC_IDX_OPER) && avs_byteenable[0])
         start_q <= avs_writedata[`SWC_OPER_START];
   end

   always_ff @(posedge clk)
   begin
      if (cfg_rst)
         dtag_q <= `SWC_RST_DTAG;
      else if (wr_take && hit(avs_address, `SWC_IDX_OPER) && avs_byteenable[0])
         dtag_q <= avs_writedata[`SWC_OPER_DTAG];
   end

   always_ff @(posedge clk)
   begin
      if (cfg_rst)
      begin
         addr_q[0] <= OWN_ADDR_HI_RST[23:16];
         addr_q[1] <= OWN_ADDR_HI_RST[15:8];
         addr_q[2] <= OWN_ADDR_HI_RST[7:0];
         addr_q[3] <= `SWC_RST_ADDR3;
         addr_q[4] <= `SWC_RST_ADDR4;
         addr_q[5] <= `SWC_RST_ADDR5;
      end
      else if (wr_take)
      begin
         for (int i = 0; i < 6; i++)
         begin
            if (hit(avs_address, `SWC_IDX_ADDR0 + 12'(i)))
               addr_q[i] <= merge(addr_q[i], avs_writedata[7:0], avs_byteenable[0]);
         end
      end
   end

   // Full 14 bits stored so jumbo lengths up to 9000 fit
   always_ff @(posedge clk)
   begin
      if (cfg_rst)
      begin
         mfl_q <= `SWC_RST_MFL;
         mfl_rsv_q <= `SWC_RST_MFL_RSV;
      end
      else if (wr_take && hit(avs_address, `SWC_IDX_MFL))
      begin
         if (avs_byteenable[0])
            mfl_q[7:0] <= avs_writedata[7:0];
         if (avs_byteenable[1])
         begin
            mfl_q[13:8] <= avs_writedata[13:8];
            mfl_rsv_q <= avs_writedata[15:14];
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (cfg_rst)
         tag_q <= `SWC_RST_TAG;
      else if (wr_take && hit(avs_address, `SWC_IDX_TAG))
      begin
         tag_q[7:0] <= merge(tag_q[7:0], avs_writedata[7:0], avs_byteenable[0]);
         tag_q[15:8] <= merge(tag_q[15:8], avs_writedata[15:8], avs_byteenable[1]);
      end
   end

   always_ff @(posedge clk)
   begin
      if (cfg_rst)
      begin
         shape_q <= `SWC_RST_SHAPE;
         police_q <= `SWC_RST_POLICE;
      end
      else if (wr_take && hit(avs_address, `SWC_IDX_CBS) && avs_byteenable[0])
      begin
         shape_q <= avs_writedata[`SWC_CBS_SHAPE];
         police_q <= avs_writedata[`SWC_CBS_POLICE];
      end
   end

   // Outputs straight from flops
   assign avs_readdata = rdata_q;
   assign avs_waitrequest = wait_q;
   assign switch_enable = start_q;
   assign double_tag_en = dtag_q;
   assign soft_reset_busy = srst_q;
   assign own_addr = {addr_q[0], addr_q[1], addr_q[2], addr_q[3], addr_q[4], addr_q[5]};
   assign max_frame_length = mfl_q;
   assign provider_tag = tag_q;
   assign shaper_credit_full = shape_q;
   assign police_credit_full = police_q;

   AST_ONE_WAIT_CYCLE: assert property (@(posedge clk) disable iff (!rst_n)
      (bus_q == SWC_BUS_IDLE) && (avs_read || avs_write)
      |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("Answer not given after exactly one wait cycle");

   AST_STRAP_READ: assert property (@(posedge clk) disable iff (!rst_n)
      (bus_q == SWC_BUS_IDLE) && avs_read && hit(avs_address, `SWC_IDX_STRAP)
      |=> avs_readdata == {28'h0, $past(strap.value)})
      else $error("Strap readback wrong");

   AST_DTAG_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
      wr_take && !srst_q && hit(avs_address, `SWC_IDX_OPER) && avs_byteenable[0]
      |=> double_tag_en == $past(avs_writedata[`SWC_OPER_DTAG]))
      else $error("Double tag bit not written");

   AST_SRST_DEFAULTS: assert property (@(posedge clk) disable iff (!rst_n)
      srst_q |=> !srst_q && !double_tag_en && max_frame_length == `SWC_RST_MFL
      && provider_tag == `SWC_RST_TAG && own_addr[47:24] == OWN_ADDR_HI_RST
      && own_addr[23:0] == {`SWC_RST_ADDR3, `SWC_RST_ADDR4, `SWC_RST_ADDR5}
      && !shaper_credit_full && police_credit_full)
      else $error("Soft reset did not restore defaults");

   AST_START_GATE: assert property (@(posedge clk) disable iff (!rst_n)
      wr_take && !srst_q && !strap_load && hit(avs_address, `SWC_IDX_OPER)
      && avs_byteenable[0] && !avs_writedata[`SWC_OPER_START] && !avs_writedata[`SWC_OPER_SRST]
      |=> !switch_enable [*2])
      else $error("Switch enable not cleared by write");

   AST_START_STRAP: assert property (@(posedge clk) disable iff (!rst_n)
      strap_load || srst_q |=> switch_enable == $past(strap.value[0]))
      else $error("Start bit not taken from strap");

   AST_ADDR_ORDER: assert property (@(posedge clk) disable iff (!rst_n)
      wr_take && !srst_q && hit(avs_address, `SWC_IDX_ADDR0) && avs_byteenable[0]
      |=> own_addr[47:40] == $past(avs_writedata[7:0]))
      else $error("Top address byte not at lowest register");

   AST_MFL_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
      wr_take && !srst_q && hit(avs_address, `SWC_IDX_MFL) && avs_byteenable[1:0] == 2'b11
      |=> max_frame_length == $past(avs_writedata[13:0])
      && mfl_rsv_q == $past(avs_writedata[15:14]))
      else $error("Length register write lost");

   AST_CBS_READ: assert property (@(posedge clk) disable iff (!rst_n)
      (bus_q == SWC_BUS_IDLE) && avs_read && hit(avs_address, `SWC_IDX_CBS)
      |=> avs_readdata[31:2] == 30'h0 && avs_readdata[1:0] == $past({shaper_credit_full,
      police_credit_full}))
      else $error("Strategy register readback wrong");

endmodule

// ### swc_global_ctrl_tb.sv
`include "swc_regs.svh"

module swc_global_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import swc_pkg::*;
   // Arbitrary top address bytes
   localparam logic [23:0] HI_RST = 24'h1e6b70;
   logic clk;
   logic rst_n;
   logic rxd_b1, rxd_b0, led_a1, led_a0;
   logic [`SWC_ADDR_W-1:0] avs_address;
   logic avs_read, avs_write;
   logic [3:0] avs_byteenable;
   logic [31:0] avs_writedata, avs_readdata;
   logic avs_waitrequest, switch_enable, double_tag_en, soft_reset_busy;
   swc_mac_t own_addr;
   logic [`SWC_MFL_LEN_W-1:0] max_frame_length;
   logic [15:0] provider_tag;
   logic shaper_credit_full, police_credit_full;
   int n_fail;
   int samples_checked;
   int cycles;
   logic [31:0] seed;
   logic [11:0] ridx [11];
   logic [31:0] rmask [11];
   logic [31:0] mdl [11];

   swc_global_ctrl #(.OWN_ADDR_HI_RST(HI_RST)) swc_global_ctrl_inst (
      .clk(clk), .rst_n(rst_n), .rxd_b1(rxd_b1), .rxd_b0(rxd_b0), .led_a1(led_a1),
      .led_a0(led_a0), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_byteenable(avs_byteenable),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .switch_enable(switch_enable),
      .double_tag_en(double_tag_en), .soft_reset_busy(soft_reset_busy),
      .own_addr(own_addr), .max_frame_length(max_frame_length),
      .provider_tag(provider_tag), .shaper_credit_full(shaper_credit_full),
      .police_credit_full(police_credit_full)
   );

   initial
   begin
      clk = 1'h0;
      forever #2.5 clk = ~clk;
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
      begin
         $display("Simulation passed");
      end
      else
      begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // A hang anywhere ends the run as a failure
   always @(posedge clk)
   begin
      cycles = cycles + 1;
      if (cycles == 8000)
      begin
         n_fail++;
         summarize();
      end
   end

   task automatic chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Request held until the edge that samples waitrequest low, released at that edge
   task automatic bus(input logic wr, input logic [`SWC_ADDR_W-1:0] a, input logic [3:0] be,
                      input logic [31:0] wd, output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge clk);
      avs_address <= a;
      avs_read <= ~wr;
      avs_write <= wr;
      avs_byteenable <= be;
      avs_writedata <= wd;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (avs_waitrequest !== 1'h0);
      chk("bus_wait_cycles", 48'd2, 48'(n));
      rd = avs_readdata;
      avs_read <= 1'h0;
      avs_write <= 1'h0;
   endtask

   task automatic wr_reg(input int i, input logic [3:0] be, input logic [31:0] wd);
      logic [31:0] m;
      logic [31:0] rd;
      m = rmask[i] & {16'h0, {8{be[1]}}, {8{be[0]}}};
      bus(1'h1, {ridx[i], 2'h0}, be, wd, rd);
      mdl[i] = (mdl[i] & ~m) | (wd & m);
   endtask

   task automatic rd_chk(input int i);
      logic [31:0] rd;
      bus(1'h0, {ridx[i], 2'h0}, 4'hf, rnd(), rd);
      chk($sformatf("reg_%h", ridx[i]), mdl[i], rd);
   endtask

   task automatic check_out();
      @(negedge clk);
      chk("switch_enable", mdl[1][0], switch_enable);
      chk("double_tag_en", mdl[1][7], double_tag_en);
      chk("soft_reset_busy", 48'h0, soft_reset_busy);
      chk("own_addr", {mdl[2][7:0], mdl[3][7:0], mdl[4][7:0], mdl[5][7:0], mdl[6][7:0],
          mdl[7][7:0]}, own_addr);
      chk("max_frame_length", mdl[8][13:0], max_frame_length);
      chk("provider_tag", mdl[9][15:0], provider_tag);
      chk("shaper_credit_full", mdl[10][1], shaper_credit_full);
      chk("police_credit_full", mdl[10][0], police_credit_full);
   endtask

   task automatic check_all();
      for (int i = 0; i < 11; i++)
      begin
         rd_chk(i);
      end
      check_out();
   endtask

   // Defaults; straps survive a soft reset so they are read from the pins
   task automatic mdl_reset();
      mdl = '{{28'h0, rxd_b1, rxd_b0, led_a1, led_a0}, {31'h0, led_a0},
              32'(HI_RST[23:16]), 32'(HI_RST[15:8]), 32'(HI_RST[7:0]),
              32'hff, 32'hff, 32'hff, 32'h7d0, 32'h9100, 32'h1};
   endtask

   initial
   begin
      int i;
      logic [31:0] d;
      logic [31:0] e;
      logic [31:0] rd;
      logic [15:0] jv [3];
      logic [`SWC_ADDR_W-1:0] ua [3];
      rst_n = 1'h0;
      {rxd_b1, rxd_b0, led_a1, led_a0} = 4'h0;
      avs_address = '0;
      avs_read = 1'h0;
      avs_write = 1'h0;
      avs_byteenable = 4'h0;
      avs_writedata = 32'h0;
      n_fail = 0;
      samples_checked = 0;
      cycles = 0;
      seed = 32'h00009384;
      ridx = '{`SWC_IDX_STRAP, `SWC_IDX_OPER, `SWC_IDX_ADDR0, `SWC_IDX_ADDR1, `SWC_IDX_ADDR2,
               `SWC_IDX_ADDR3, `SWC_IDX_ADDR4, `SWC_IDX_ADDR5, `SWC_IDX_MFL, `SWC_IDX_TAG,
               `SWC_IDX_CBS};
      rmask = '{32'h0, 32'h81, 32'hff, 32'hff, 32'hff, 32'hff, 32'hff, 32'hff, 32'hffff,
                32'hffff, 32'h3};
      jv = '{16'h2328, 16'hffff, 16'h4000};
      ua = '{14'h0c04, 14'h0c09, 14'h0c3c};
      // Two power-ups, start strap low then high
      for (int r = 0; r < 2; r++)
      begin
         d = rnd();
         @(posedge clk);
         rst_n <= 1'h0;
         {rxd_b1, rxd_b0, led_a1} <= d[2:0];
         led_a0 <= r[0];
         repeat (16) @(posedge clk);
         rst_n <= 1'h1;
         repeat (12) @(posedge clk);
         mdl_reset();
         check_all();
         for (int k = 0; k < 3; k++)
         begin
            bus(1'h1, ua[k], 4'hf, 32'hffffffff, rd);
            bus(1'h0, ua[k], 4'hf, 32'h0, rd);
            chk("unmapped", 48'h0, rd);
         end
         repeat (40)
         begin
            i = int'(rnd() % 11);
            d = rnd();
            e = rnd();
            // Soft reset bit kept out of random traffic
            if (i == 1)
            begin
               d[1] = 1'h0;
            end
            wr_reg(i, e[3:0], d);
            rd_chk(i);
            check_out();
         end
         for (int k = 0; k < 3; k++)
         begin
            wr_reg(8, 4'h3, {16'h0, jv[k]});
            rd_chk(8);
            check_out();
         end
         check_all();
         wr_reg(1, 4'h1, 32'h83);
         // Pulse stands only in the cycle right after the answer edge
         @(negedge clk);
         chk("soft_reset_pulse", 48'h1, soft_reset_busy);
         mdl_reset();
         check_all();
      end
      summarize();
   end
endmodule
